// File: verilog/cdma_map.svh
// register offsets, field positions, reset values and timing counts
// for the cascaded dma controller; included by the core.
//
// Contract
// R1: first controller holds channels 0-3, 8-bit
// R2: second controller holds 4-7; 4 cascades first
// R3: 8-bit channels: 32-bit address, 64 KB pages
// R4: 16-bit channels: 32-bit address, 128 KB pages
// R5: channels 5-7 move even-aligned 16-bit words
// R6: only hardware request lines start transfers
// R7: per-channel single, block, demand or cascade mode
// R8: single mode: one cycle, then release bus
// R9: block mode: all transfers without releasing bus
// R10: demand mode: run while request high, until terminal
// R11: slave hold feeds master channel 4 request
// R12: each channel does read, write or verify
// R13: reset puts both controllers in fixed priority
// R14: fixed order 0,1,2,3,5,6,7
// R15: address/count write loads base and current
// R16: address/count read returns current only
// R17: ready input stretches transfer cycles
// R18: cascade channel lets bus master own bus
// R19: byte pointer selects low then high byte
// R20: rotating: last serviced channel becomes lowest
// R21: low page write clears high page
// R22: terminal count ends sequence, releases bus
`ifndef CDMA_MAP_SVH
`define CDMA_MAP_SVH

// ============================================================
// register offsets
`define CDMA_MODE_BASE 8'h20
`define CDMA_CMD_SLAVE 8'h28
`define CDMA_CMD_MASTER 8'h29
`define CDMA_MASK 8'h2A
`define CDMA_STATUS 8'h2B
`define CDMA_CLR_PTR 8'h2C
`define CDMA_REQ 8'h2D

// ============================================================
// channel register fields, addr[1:0]
`define CDMA_F_ADDR 2'h0
`define CDMA_F_CNT 2'h1
`define CDMA_F_LOPG 2'h2
`define CDMA_F_HIPG 2'h3

// ============================================================
// bit fields
`define CDMA_ROT_BIT 4
`define CDMA_MODE_TT_LSB 0
`define CDMA_MODE_TM_LSB 2
`define CDMA_MODE_AUTO_BIT 4
`define CDMA_CASC_CH 3'h4

// ============================================================
// reset values
`define CDMA_MASK_RST 8'hFF
`define CDMA_CMD_RST 8'h00

// ============================================================
// timing
`define CDMA_CLK_NS 25
`define CDMA_CMD_NS 100
`define CDMA_CMD_CYC ((`CDMA_CMD_NS + `CDMA_CLK_NS - 1) / `CDMA_CLK_NS)

`endif

// File: verilog/cdma_pkg.sv
// types shared by the cascaded dma controller
// assumes nothing of its surroundings
package cdma_pkg;

  typedef logic [7:0] cdma_byte_t;

  typedef enum logic [1:0] {
    CDMA_TM_DEMAND = 2'h0,
    CDMA_TM_SINGLE = 2'h1,
    CDMA_TM_BLOCK = 2'h2,
    CDMA_TM_CASCADE = 2'h3
  } cdma_tmode_e;

  typedef enum logic [1:0] {
    CDMA_TT_VERIFY = 2'h0,
    CDMA_TT_WRITE = 2'h1,
    CDMA_TT_READ = 2'h2,
    CDMA_TT_RSVD = 2'h3
  } cdma_xtype_e;

  typedef enum logic [2:0] {
    CDMA_ST_IDLE = 3'h0,
    CDMA_ST_HOLD = 3'h1,
    CDMA_ST_ADDR = 3'h2,
    CDMA_ST_CMD = 3'h3,
    CDMA_ST_WAIT = 3'h4,
    CDMA_ST_CASC = 3'h5
  } cdma_state_e;

endpackage

// File: verilog/cdma_ctrl.sv
// seven-channel dma engine: two cascaded controllers, one bus sequencer
// assumes ref_clk_i at 40 MHz; drq_i and ready_i are asynchronous pins;
// bus_gnt_i and the register port are on ref_clk_i.
`timescale 1ns/1ps
`include "cdma_map.svh"

module cdma_ctrl (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire cdma_pkg::cdma_byte_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output cdma_pkg::cdma_byte_t reg_rdata_o,
  input wire logic [7:0] drq_i,
  output logic [7:0] dack_n_o,
  input wire logic ready_i,
  output logic bus_req_o,
  input wire logic bus_gnt_i,
  output logic [31:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic io_rd_o,
  output logic io_wr_o,
  output logic word_o,
  output logic tc_o
);
  import cdma_pkg::*;

  localparam logic [2:0] CMD_CYC = 3'(`CDMA_CMD_CYC);

  // ============================================================
  // pin synchronisers
  logic [7:0] drq_meta, drq_sync;
  logic ready_meta, ready_sync;

  always_ff @(posedge ref_clk_i) begin
    drq_meta <= rst_i ? 8'h00 : drq_i;
    drq_sync <= rst_i ? 8'h00 : drq_meta;
    ready_meta <= !rst_i && ready_i;
    ready_sync <= !rst_i && ready_meta;
  end

  // ============================================================
  // register storage
  logic [15:0] base_addr [8], cur_addr [8], base_cnt [8], cur_cnt [8];
  logic [7:0] lo_page [8], hi_page [8], mode_reg [8];
  logic [7:0] cmd_slave, cmd_master, mask, tc_stat;
  logic byte_ptr;
  logic [1:0] slave_last, master_last;

  cdma_state_e state, next_state;
  logic [2:0] sel, cmd_cnt;

  // ============================================================
  // register decode
  logic ch_hit;
  logic [2:0] ch_idx;
  logic [1:0] ch_fld;
  logic ptr_access;

  assign ch_hit = (reg_addr_i[7:5] == 3'h0);
  assign ch_idx = reg_addr_i[4:2];
  assign ch_fld = reg_addr_i[1:0];
  assign ptr_access = ch_hit && (reg_wr_i || reg_rd_i) &&
                      (ch_fld == `CDMA_F_ADDR || ch_fld == `CDMA_F_CNT);

  // ============================================================
  // requests and arbitration
  // no software request register exists: only drq pins count (see R6)
  logic [7:0] req;
  logic slave_hold_request, master_first_request_input, any_req;
  logic [2:0] slave_win, master_win, winner;

  // returns {valid, index}; rotation starts after the last served (see R20)
  function automatic logic [2:0] cdma_pick(input logic [3:0] rq,
                                           input logic rot,
                                           input logic [1:0] last);
    logic [2:0] r;
    logic [1:0] k;
    r = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      k = rot ? 2'(last + 2'(i) + 2'h1) : 2'(i);
      if (rq[k]) begin
        r = {1'b1, k};
      end
    end
    return r;
  endfunction

  assign req = drq_sync & ~mask & 8'hEF; // channel 4 has no pin (see R2)
  assign slave_win = cdma_pick(req[3:0], cmd_slave[`CDMA_ROT_BIT],
                               slave_last); // see R1
  assign slave_hold_request = slave_win[2];
  // slave hold drives master channel 4 request (see R11)
  assign master_first_request_input = slave_hold_request;
  assign master_win = cdma_pick({req[7:5], master_first_request_input},
                                cmd_master[`CDMA_ROT_BIT], master_last);
  // channel 4 winning hands the bus to the slave winner (see R14)
  assign winner = (master_win[1:0] == 2'h0) ? {1'b0, slave_win[1:0]} :
                  {1'b1, master_win[1:0]};
  assign any_req = master_win[2];

  // ============================================================
  // sequencer
  cdma_tmode_e sel_tm;
  cdma_xtype_e sel_tt;
  logic sel_auto, cyc_end, tc_hit, casc_end;

  assign sel_tm = cdma_tmode_e'(mode_reg[sel][`CDMA_MODE_TM_LSB +: 2]);
  assign sel_tt = cdma_xtype_e'(mode_reg[sel][`CDMA_MODE_TT_LSB +: 2]);
  assign sel_auto = mode_reg[sel][`CDMA_MODE_AUTO_BIT];
  // ready low stretches the cycle (see R17)
  assign cyc_end = (state == CDMA_ST_WAIT) && ready_sync;
  assign tc_hit = (cur_cnt[sel] == 16'h0000);
  assign casc_end = (state == CDMA_ST_CASC) && !drq_sync[sel];

  always_comb begin
    next_state = state;
    case (state)
      CDMA_ST_IDLE: if (any_req) next_state = CDMA_ST_HOLD;
      CDMA_ST_HOLD: begin
        if (!any_req) begin
          next_state = CDMA_ST_IDLE;
        end else if (bus_gnt_i) begin
          // cascade channel gives the bus to the requester (see R18)
          next_state = (mode_reg[winner][`CDMA_MODE_TM_LSB +: 2] ==
                        CDMA_TM_CASCADE) ? CDMA_ST_CASC : CDMA_ST_ADDR;
        end
      end
      CDMA_ST_ADDR: next_state = CDMA_ST_CMD;
      CDMA_ST_CMD: if (cmd_cnt == CMD_CYC - 3'h1) next_state = CDMA_ST_WAIT;
      CDMA_ST_WAIT: begin
        if (ready_sync) begin
          if (tc_hit) begin
            next_state = CDMA_ST_IDLE; // see R22
          end else begin
            case (sel_tm)
              CDMA_TM_SINGLE: next_state = CDMA_ST_IDLE; // see R8
              CDMA_TM_BLOCK: next_state = CDMA_ST_ADDR; // see R9
              CDMA_TM_DEMAND: begin
                // continue only while request holds (see R10)
                next_state = (drq_sync[sel] && !mask[sel]) ?
                             CDMA_ST_ADDR : CDMA_ST_IDLE;
              end
              default: next_state = CDMA_ST_IDLE;
            endcase
          end
        end
      end
      CDMA_ST_CASC: if (casc_end) next_state = CDMA_ST_IDLE;
      default: next_state = CDMA_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    state <= rst_i ? CDMA_ST_IDLE : next_state;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sel <= 3'h0;
    end else if (state == CDMA_ST_HOLD && bus_gnt_i) begin
      sel <= winner;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    cmd_cnt <= (state == CDMA_ST_CMD && !rst_i) ? cmd_cnt + 3'h1 : 3'h0;
  end

  // last served channel per controller, for rotation (see R20)
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      slave_last <= 2'h3;
      master_last <= 2'h3;
    end else if (cyc_end || casc_end) begin
      if (sel[2]) begin
        master_last <= sel[1:0];
      end else begin
        slave_last <= sel[1:0];
        master_last <= 2'h0;
      end
    end
  end

  // ============================================================
  // bus side outputs
  logic slave_hold_acknowledge_input, master_first_acknowledge_output;
  logic ack_phase;

  assign ack_phase = (state == CDMA_ST_ADDR) || (state == CDMA_ST_CMD) ||
                     (state == CDMA_ST_WAIT) || (state == CDMA_ST_CASC);
  assign bus_req_o = (state != CDMA_ST_IDLE);
  // master channel 4 acknowledge feeds slave hold acknowledge (see R11)
  assign master_first_acknowledge_output = ack_phase && !sel[2];
  assign slave_hold_acknowledge_input = master_first_acknowledge_output;

  always_comb begin
    dack_n_o = 8'hFF;
    if (slave_hold_acknowledge_input) begin
      dack_n_o[sel] = 1'b0;
    end else if (ack_phase) begin
      dack_n_o[sel] = 1'b0;
    end
  end

  logic cmd_on;
  assign cmd_on = (next_state == CDMA_ST_CMD) ||
                  (next_state == CDMA_ST_WAIT);

  // verify drives no command line (see R12)
  always_ff @(posedge ref_clk_i) begin
    mem_rd_o <= !rst_i && cmd_on && (sel_tt == CDMA_TT_READ);
    io_wr_o <= !rst_i && cmd_on && (sel_tt == CDMA_TT_READ);
    mem_wr_o <= !rst_i && cmd_on && (sel_tt == CDMA_TT_WRITE);
    io_rd_o <= !rst_i && cmd_on && (sel_tt == CDMA_TT_WRITE);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mem_addr_o <= 32'h0000_0000;
      word_o <= 1'b0;
    end else if (sel[2]) begin
      // word channels: address is a word index, bit 0 forced low
      mem_addr_o <= {hi_page[sel], lo_page[sel][7:1], cur_addr[sel],
                     1'b0}; // see R4 see R5
      word_o <= 1'b1;
    end else begin
      mem_addr_o <= {hi_page[sel], lo_page[sel], cur_addr[sel]}; // see R3
      word_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    tc_o <= !rst_i && cyc_end && tc_hit;
  end

  // ============================================================
  // channel registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        base_addr[i] <= 16'h0000;
        cur_addr[i] <= 16'h0000;
        base_cnt[i] <= 16'h0000;
        cur_cnt[i] <= 16'h0000;
        lo_page[i] <= 8'h00;
        hi_page[i] <= 8'h00;
      end
    end else begin
      // address wraps inside 16 bits, never crossing the page (see R3)
      if (cyc_end) begin
        if (tc_hit && sel_auto) begin
          cur_addr[sel] <= base_addr[sel];
          cur_cnt[sel] <= base_cnt[sel];
        end else begin
          cur_addr[sel] <= cur_addr[sel] + 16'h0001;
          cur_cnt[sel] <= cur_cnt[sel] - 16'h0001;
        end
      end
      if (reg_wr_i && ch_hit) begin
        case (ch_fld)
          `CDMA_F_ADDR: begin
            // base and current load together (see R15 see R19)
            if (byte_ptr) begin
              base_addr[ch_idx][15:8] <= reg_wdata_i;
              cur_addr[ch_idx][15:8] <= reg_wdata_i;
            end else begin
              base_addr[ch_idx][7:0] <= reg_wdata_i;
              cur_addr[ch_idx][7:0] <= reg_wdata_i;
            end
          end
          `CDMA_F_CNT: begin
            if (byte_ptr) begin
              base_cnt[ch_idx][15:8] <= reg_wdata_i; // see R15
              cur_cnt[ch_idx][15:8] <= reg_wdata_i;
            end else begin
              base_cnt[ch_idx][7:0] <= reg_wdata_i;
              cur_cnt[ch_idx][7:0] <= reg_wdata_i;
            end
          end
          `CDMA_F_LOPG: begin
            lo_page[ch_idx] <= reg_wdata_i;
            hi_page[ch_idx] <= 8'h00; // see R21
          end
          `CDMA_F_HIPG: begin
            hi_page[ch_idx] <= reg_wdata_i;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      byte_ptr <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == `CDMA_CLR_PTR) begin
      byte_ptr <= 1'b0;
    end else if (ptr_access) begin
      byte_ptr <= ~byte_ptr; // see R19
    end
  end

  // ============================================================
  // mode, command, mask and status
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        mode_reg[i] <= 8'h00;
      end
    end else if (reg_wr_i && reg_addr_i[7:3] == `CDMA_MODE_BASE >> 3) begin
      mode_reg[reg_addr_i[2:0]] <= reg_wdata_i; // see R7 see R12
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cmd_slave <= `CDMA_CMD_RST; // fixed priority out of reset (see R13)
      cmd_master <= `CDMA_CMD_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `CDMA_CMD_SLAVE) begin
        cmd_slave <= reg_wdata_i;
      end
      if (reg_addr_i == `CDMA_CMD_MASTER) begin
        cmd_master <= reg_wdata_i;
      end
    end
  end

  // terminal count without auto reload masks the channel; set wins
  logic [7:0] tc_set;
  always_comb begin
    tc_set = 8'h00;
    if (cyc_end && tc_hit) begin
      tc_set[sel] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mask <= `CDMA_MASK_RST;
    end else if (reg_wr_i && reg_addr_i == `CDMA_MASK) begin
      mask <= reg_wdata_i | (sel_auto ? 8'h00 : tc_set);
    end else begin
      mask <= mask | (sel_auto ? 8'h00 : tc_set); // see R22
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tc_stat <= 8'h00;
    end else if (reg_rd_i && reg_addr_i == `CDMA_STATUS) begin
      tc_stat <= tc_set;
    end else begin
      tc_stat <= tc_stat | tc_set;
    end
  end

  // ============================================================
  // read port, data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ch_hit) begin
      case (ch_fld)
        // only current copies are visible (see R16)
        `CDMA_F_ADDR: reg_rdata_o <= byte_ptr ? cur_addr[ch_idx][15:8] :
                                     cur_addr[ch_idx][7:0];
        `CDMA_F_CNT: reg_rdata_o <= byte_ptr ? cur_cnt[ch_idx][15:8] :
                                    cur_cnt[ch_idx][7:0];
        `CDMA_F_LOPG: reg_rdata_o <= lo_page[ch_idx];
        default: reg_rdata_o <= hi_page[ch_idx];
      endcase
    end else if (reg_addr_i[7:3] == `CDMA_MODE_BASE >> 3) begin
      reg_rdata_o <= mode_reg[reg_addr_i[2:0]];
    end else begin
      case (reg_addr_i)
        `CDMA_CMD_SLAVE: reg_rdata_o <= cmd_slave;
        `CDMA_CMD_MASTER: reg_rdata_o <= cmd_master;
        `CDMA_MASK: reg_rdata_o <= mask;
        `CDMA_STATUS: reg_rdata_o <= tc_stat;
        `CDMA_REQ: reg_rdata_o <= req;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule // cdma_ctrl

// File: tb/cdma_periph.sv
// peripheral and host-arbiter model facing the dma controller
// assumes the bench sets want_i per channel and slow_i for long cycles
`timescale 1ns/1ps

module cdma_periph (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] want_i,
  input wire logic slow_i,
  input wire logic bus_req_i,
  input wire logic cmd_i,
  output logic [7:0] drq_o,
  output logic bus_gnt_o,
  output logic ready_o
);
  logic gnt = 1'b0;
  logic [2:0] gnt_wait = 3'h0;
  logic [2:0] cmd_age = 3'h0;

  // ============================================================
  // requests: the bench lowers one when the device cannot go on
  assign drq_o = want_i;
  assign bus_gnt_o = gnt;

  // ============================================================
  // grant one cycle after the request, three when slow
  always @(posedge ref_clk_i) begin
    if (rst_i || !bus_req_i) begin
      gnt_wait <= 3'h0;
      gnt <= 1'b0;
    end else begin
      if (gnt_wait != 3'h7)
        gnt_wait <= gnt_wait + 3'h1;
      gnt <= (gnt_wait >= (slow_i ? 3'h2 : 3'h0));
    end
  end

  // ============================================================
  // ready held low for the first six command cycles when slow
  always @(posedge ref_clk_i) begin
    if (rst_i || !cmd_i)
      cmd_age <= 3'h0;
    else if (cmd_age != 3'h7)
      cmd_age <= cmd_age + 3'h1;
  end
  assign ready_o = !(slow_i && cmd_i && cmd_age < 3'h6);
endmodule // cdma_periph

// File: tb/cdma_ctrl_chk.sv
// concurrent checks on the ports of the dma controller
// assumes binding to cdma_ctrl; one clock domain, synchronous reset
`timescale 1ns/1ps

module cdma_ctrl_chk (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire cdma_pkg::cdma_byte_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire cdma_pkg::cdma_byte_t reg_rdata_o,
  input wire logic [7:0] drq_i,
  input wire logic [7:0] dack_n_o,
  input wire logic ready_i,
  input wire logic bus_req_o,
  input wire logic bus_gnt_i,
  input wire logic [31:0] mem_addr_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic io_rd_o,
  input wire logic io_wr_o,
  input wire logic word_o,
  input wire logic tc_o
);
  import cdma_pkg::*;
  logic cmd;
  assign cmd = mem_rd_o | mem_wr_o | io_rd_o | io_wr_o;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // ============================================================
  // sequences
  sequence s_cmd_start;
    !cmd ##1 cmd;
  endsequence
  sequence s_ready_low;
    (cmd && !ready_i)[*3];
  endsequence

  // ============================================================
  // properties
  property p_casc_quiet;
    dack_n_o[4];
  endproperty
  property p_one_ack;
    $onehot0(~dack_n_o);
  endproperty
  property p_dir;
    !(mem_rd_o && mem_wr_o) && mem_rd_o == io_wr_o && mem_wr_o == io_rd_o;
  endproperty
  property p_cmd_owner;
    cmd |-> bus_req_o && dack_n_o != 8'hFF;
  endproperty
  property p_cmd_min;
    s_cmd_start |-> cmd[*4];
  endproperty
  property p_ready_hold;
    s_ready_low |=> cmd;
  endproperty
  property p_tc_pulse;
    tc_o |=> !tc_o;
  endproperty
  property p_tc_release;
    tc_o |-> ##[0:3] !bus_req_o;
  endproperty
  property p_word_even;
    word_o && cmd |-> !mem_addr_o[0] && dack_n_o[7:5] != 3'h7;
  endproperty
  property p_rdata_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  property p_hw_only;
    $rose(bus_req_o) |->
      ($past(drq_i, 2) | $past(drq_i, 3) | $past(drq_i, 4)) != 8'h00;
  endproperty

  // ============================================================
  // assertions
  a_casc_quiet: assert property (p_casc_quiet)
    else $error("cascade channel acknowledged");
  a_one_ack: assert property (p_one_ack)
    else $error("two channels acknowledged");
  a_dir: assert property (p_dir)
    else $error("command lines disagree on direction");
  a_cmd_owner: assert property (p_cmd_owner)
    else $error("command without bus and acknowledge");
  a_cmd_min: assert property (p_cmd_min)
    else $error("command shorter than four cycles");
  a_ready_hold: assert property (p_ready_hold)
    else $error("cycle ended while ready low");
  a_tc_pulse: assert property (p_tc_pulse)
    else $error("terminal count longer than one cycle");
  a_tc_release: assert property (p_tc_release)
    else $error("bus kept after terminal count");
  a_word_even: assert property (p_word_even)
    else $error("word transfer odd or on byte channel");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its cycle");
  a_hw_only: assert property (p_hw_only)
    else $error("bus request without hardware request");
endmodule // cdma_ctrl_chk

bind cdma_ctrl cdma_ctrl_chk u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .drq_i(drq_i),
  .dack_n_o(dack_n_o), .ready_i(ready_i), .bus_req_o(bus_req_o),
  .bus_gnt_i(bus_gnt_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
  .mem_wr_o(mem_wr_o), .io_rd_o(io_rd_o), .io_wr_o(io_wr_o),
  .word_o(word_o), .tc_o(tc_o));

// File: tb/test_cascaded_dma_controller.sv
// self-checking bench for the cascaded dma controller
// assumes the peripheral model beside the core and the bound checker
`timescale 1ns/1ps

module test_cascaded_dma_controller;
  import cdma_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  cdma_byte_t reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  cdma_byte_t reg_rdata_o;
  logic [7:0] drq_i, dack_n_o;
  logic [7:0] want = 8'h00;
  logic slow = 1'b0;
  logic ready_i, bus_req_o, bus_gnt_i, cmd, req_d, cmd_d;
  logic [31:0] mem_addr_o;
  logic mem_rd_o, mem_wr_o, io_rd_o, io_wr_o, word_o, tc_o;
  int n_fail = 0, comparisons = 0, cycles = 0;
  int n_rel = 0, n_tc = 0, n_cmd = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;
  assign cmd = mem_rd_o | mem_wr_o | io_rd_o | io_wr_o;

  cdma_ctrl dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .drq_i(drq_i),
    .dack_n_o(dack_n_o), .ready_i(ready_i), .bus_req_o(bus_req_o),
    .bus_gnt_i(bus_gnt_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .io_rd_o(io_rd_o), .io_wr_o(io_wr_o),
    .word_o(word_o), .tc_o(tc_o));
  cdma_periph u_periph (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .want_i(want), .slow_i(slow), .bus_req_i(bus_req_o), .cmd_i(cmd),
    .drq_o(drq_i), .bus_gnt_o(bus_gnt_i), .ready_o(ready_i));

  // ============================================================
  // monitors: bus releases, command starts, terminal counts, timeout
  always @(posedge ref_clk_i) begin
    req_d <= bus_req_o;
    cmd_d <= cmd;
    cycles <= cycles + 1;
    if (req_d === 1'b1 && bus_req_o === 1'b0)
      n_rel <= n_rel + 1;
    if (cmd_d === 1'b0 && cmd === 1'b1)
      n_cmd <= n_cmd + 1;
    if (tc_o === 1'b1)
      n_tc <= n_tc + 1;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end

  // ============================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      #1;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic prog(input logic [2:0] ch, input logic [15:0] a,
                      input logic [15:0] n, input logic [7:0] lo,
                      input logic [7:0] hi, input logic [7:0] m);
    wr(8'h2C, 8'h00);
    wr({3'h0, ch, 2'h0}, a[7:0]);
    wr({3'h0, ch, 2'h0}, a[15:8]);
    wr({3'h0, ch, 2'h1}, n[7:0]);
    wr({3'h0, ch, 2'h1}, n[15:8]);
    wr({3'h0, ch, 2'h2}, lo);
    wr({3'h0, ch, 2'h3}, hi);
    wr({5'h04, ch}, m);
  endtask

  // waits for one command window and checks address, lines and width
  task automatic xfer(input logic [31:0] a, input logic [3:0] c,
                      input logic w);
    for (int i = 0; i < 200 && cmd !== 1'b1; i++)
      step(1);
    chk(mem_addr_o, a);
    chk({mem_rd_o, mem_wr_o, io_rd_o, io_wr_o}, c);
    chk(word_o, w);
    for (int i = 0; i < 200 && cmd !== 1'b0; i++)
      step(1);
  endtask

  task automatic wait_ack;
    for (int i = 0; i < 200 && dack_n_o === 8'hFF; i++)
      step(1);
  endtask

  // ============================================================
  // scenarios
  task automatic t_reset;
    logic [7:0] d;
    chk({dack_n_o, bus_req_o, tc_o}, 10'h3FC);
    rd(8'h2A, d);
    chk(d, 8'hFF);
    rd(8'h2B, d);
    chk(d, 8'h00);
    rd(8'h40, d);
    chk(d, 8'h00);
  endtask

  task automatic t_regs;
    logic [7:0] d;
    prog(3'h1, 16'hBEEF, 16'h1234, 8'h01, 8'h00, 8'h00);
    wr(8'h07, 8'h5A);
    wr(8'h06, 8'h77);
    rd(8'h07, d);
    chk(d, 8'h00);
    wr(8'h2C, 8'h00);
    rd(8'h04, d);
    chk(d, 8'hEF);
    rd(8'h04, d);
    chk(d, 8'hBE);
    rd(8'h05, d);
    chk(d, 8'h34);
    wr(8'h2A, 8'h00);
    wr(8'h2D, 8'hFF);
    step(10);
    chk(bus_req_o, 1'b0);
    wr(8'h2A, 8'hFF);
  endtask

  task automatic t_single;
    logic [7:0] d;
    int r, t;
    prog(3'h2, 16'h1234, 16'h0001, 8'h56, 8'h78, 8'h06);
    wr(8'h2A, 8'hFB);
    r = n_rel;
    t = n_tc;
    @(posedge ref_clk_i);
    want <= 8'h04;
    xfer(32'h78561234, 4'b1001, 1'b0);
    xfer(32'h78561235, 4'b1001, 1'b0);
    @(posedge ref_clk_i);
    want <= 8'h00;
    step(10);
    chk(n_rel - r, 2);
    chk(n_tc - t, 1);
    wr(8'h2C, 8'h00);
    rd(8'h08, d);
    chk(d, 8'h36);
  endtask

  task automatic t_block;
    int r, t;
    prog(3'h0, 16'hFFFF, 16'h0002, 8'h11, 8'h22, 8'h09);
    wr(8'h2A, 8'hFE);
    r = n_rel;
    t = n_tc;
    @(posedge ref_clk_i);
    want <= 8'h01;
    xfer(32'h2211FFFF, 4'b0110, 1'b0);
    @(posedge ref_clk_i);
    want <= 8'h00;
    xfer(32'h22110000, 4'b0110, 1'b0);
    xfer(32'h22110001, 4'b0110, 1'b0);
    step(10);
    chk(n_rel - r, 1);
    chk(n_tc - t, 1);
  endtask

  task automatic t_demand;
    int r, t, k;
    prog(3'h6, 16'hFFFF, 16'h0005, 8'h03, 8'h00, 8'h01);
    wr(8'h2A, 8'hBF);
    r = n_rel;
    t = n_tc;
    k = n_cmd;
    @(posedge ref_clk_i);
    slow <= 1'b1;
    want <= 8'h40;
    xfer(32'h0003FFFE, 4'b0110, 1'b1);
    @(posedge ref_clk_i);
    want <= 8'h00;
    xfer(32'h00020000, 4'b0110, 1'b1);
    step(20);
    chk(n_cmd - k, 2);
    chk(n_rel - r, 1);
    chk(n_tc - t, 0);
    @(posedge ref_clk_i);
    slow <= 1'b0;
  endtask

  task automatic t_prio;
    int k;
    prog(3'h3, 16'h0100, 16'h0000, 8'h00, 8'h00, 8'h04);
    prog(3'h5, 16'h0200, 16'h0000, 8'h00, 8'h00, 8'h05);
    wr(8'h2A, 8'hD7);
    k = n_cmd;
    @(posedge ref_clk_i);
    want <= 8'h28;
    wait_ack();
    chk(dack_n_o, 8'hF7);
    xfer(32'h00000400, 4'b0110, 1'b1);
    chk(n_cmd - k, 1);
    @(posedge ref_clk_i);
    want <= 8'h00;
    step(10);
  endtask

  task automatic t_casc;
    int k;
    wr(8'h27, 8'h0C);
    wr(8'h2A, 8'h7F);
    k = n_cmd;
    @(posedge ref_clk_i);
    want <= 8'h80;
    wait_ack();
    chk(dack_n_o, 8'h7F);
    step(5);
    chk({bus_req_o, dack_n_o[7]}, 2'b10);
    @(posedge ref_clk_i);
    want <= 8'h00;
    step(10);
    chk(dack_n_o, 8'hFF);
    chk(n_cmd - k, 0);
  endtask

  // ============================================================
  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_single();
    t_block();
    t_demand();
    t_prio();
    t_casc();
    results();
  end
endmodule // test_cascaded_dma_controller
